// >>> rtl/cssc_map.svh
// Purpose: offsets, field codes, reset values and counts of the clock control unit
// Assumes: included by bare name after the package
// Notes:   fuse codes are raw stored values, 0 = programmed
`ifndef CSSC_MAP_SVH
`define CSSC_MAP_SVH

`define CSSC_SRC_EXT       4'h0
`define CSSC_SRC_RC        4'h2
`define CSSC_SRC_LFO       4'h4
`define CSSC_SRC_LFX       4'h6
`define CSSC_SUT_LONG      2'h2
`define CSSC_SUT_RSVD      2'h3
`define CSSC_FUSE_PROG     1'b0

`define CSSC_SHIP_SRC      4'h2
`define CSSC_SHIP_SUT      2'h2
`define CSSC_SHIP_DIV8     1'b0
`define CSSC_SHIP_RSTDIS   1'b1
`define CSSC_SHIP_TRIM     8'h80

`define CSSC_CK_6          16'h0006
`define CSSC_CK_14         16'h000E
`define CSSC_CK_258        16'h0102
`define CSSC_CK_1K         16'h0400
`define CSSC_CK_16K        16'h4000
`define CSSC_CK_32K        16'h8000
`define CSSC_WDT_NONE      14'h0000
`define CSSC_WDT_4MS       14'h0200
`define CSSC_WDT_64MS      14'h2000

`define CSSC_DIV_EIGHT     4'h8
`define CSSC_DIV_ONE       4'h1
`define CSSC_LOAD_WAIT     2'h3

`define CSSC_REG_TRIM      6'h00
`define CSSC_REG_STATUS    6'h01
`define CSSC_REG_FUSE      6'h02
`define CSSC_ST_WAKE_BIT   16
`define CSSC_ST_EXEC_BIT   17
`define CSSC_ST_RSVD_BIT   18

`endif

// >>> rtl/cssc_pkg.sv
// Purpose: types shared by the clock control unit files
// Assumes: nothing
// Notes:   constants live in cssc_map.svh
package cssc_pkg;

  typedef enum logic [2:0] {
    ST_LOAD, ST_RESET_WDT, ST_RESET_CK, ST_RUN, ST_SLEEP, ST_WAKE
  } cssc_state_t;

  typedef enum logic [2:0] {
    KIND_EXT, KIND_RC, KIND_LFO, KIND_LFX, KIND_XTAL
  } cssc_kind_t;

  typedef enum logic [1:0] {
    SLP_IDLE, SLP_NOISE, SLP_POWERDOWN, SLP_STANDBY
  } cssc_slpmode_t;

  typedef struct packed {
    logic [3:0] srcSel;
    logic [1:0] sutSel;
    logic       divEight;
    logic       rstPinDis;
    logic [7:0] trim;
  } cssc_fuse_t;

  typedef struct packed {
    logic wdt;
    logic xtal;
    logic lfx;
    logic lfo;
    logic rc;
    logic ext;
  } cssc_osc_t;

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic rise;
  } cssc_sync_t;

  typedef struct packed {
    cssc_state_t   state;
    cssc_fuse_t    fuseMeta;
    cssc_fuse_t    fuseSync;
    cssc_fuse_t    fuse;
    logic [1:0]    loadCnt;
    logic [15:0]   ckCnt;
    logic [13:0]   wdtCnt;
    logic [7:0]    trim;
    logic [3:0]    divisor;
    logic [3:0]    divCnt;
    cssc_slpmode_t mode;
    logic          wakeSeen;
    logic          execEn;
    logic [3:0]    domEn;
    logic          ack;
    logic [31:0]   rdata;
  } cssc_regs_t;

endpackage

// >>> rtl/cssc_tick_sync.sv
// Purpose: two-flop synchroniser with rising edge pulse
// Assumes: input is asynchronous to ref_clk, slower than half its rate
// Notes:   the meta stage feeds only the sync stage
`timescale 1ns/1ns
`default_nettype none
module cssc_tick_sync (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      rise
);
  import cssc_pkg::*;

  cssc_sync_t cur_r;
  cssc_sync_t cur_nxt;

  always_comb begin
    cur_nxt      = cur_r;
    cur_nxt.meta = din;
    cur_nxt.sync = cur_r.meta;
    cur_nxt.last = cur_r.sync;
    cur_nxt.rise = cur_r.sync & ~cur_r.last;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign rise = cur_r.rise;
endmodule
`default_nettype wire

// >>> rtl/cssc_clock_control.sv
// Purpose: clock source select, start-up sequencing, trim and domain clock enables
// Assumes: oscillator pins arrive as slow tick levels, sampled on ref_clk
// Notes:   domain outputs are one-cycle clock enables, not gated clocks
`timescale 1ns/1ns
`default_nettype none
`include "cssc_map.svh"
// How it works
// - four-bit fuse code picks the clock source
// - fuse bit zero means programmed
// - wake from power-down counts source start-up cycles
// - reset adds extra delay on watchdog oscillator
// - 4 ms is 512, 64 ms 8192 ticks
// - external clock: 6 wake, 14/+4ms/+64ms reset
// - RC oscillator uses same delays, ships at 10
// - 128 kHz oscillator uses same delay table
// - reset pin disabled lengthens code 00 delay on RC and 128 kHz only
// - factory trim loaded into calibration during reset
// - software may overwrite the oscillator trim
// - reset time-out always counts watchdog ticks
// - separate core, io, flash, converter clock domains
// - wake input caught whatever the io domain
// - flash clock runs with the core clock
// - converter clock keeps running in noise reduction
// - shipped fuses select RC with divide-by-eight
// - divide-by-eight fuse starts prescaler at eight
module cssc_clock_control #(
  parameter logic [13:0] WDT_SHORT = `CSSC_WDT_4MS,
  parameter logic [13:0] WDT_LONG  = `CSSC_WDT_64MS
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire cssc_pkg::cssc_fuse_t  fusePins,
  input  wire cssc_pkg::cssc_osc_t   oscPins,
  input  wire logic                  wakePin,
  input  wire logic                  sleepReq,
  input  wire cssc_pkg::cssc_slpmode_t sleepMode,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic                       wb_ack_o,
  output logic [31:0]                wb_dat_o,
  output logic                       coreDomainClock,
  output logic                       ioDomainClock,
  output logic                       flashDomainClock,
  output logic                       converterDomainClock,
  output logic                       execEnable,
  output logic [7:0]                 oscillatorTrimValue,
  output cssc_pkg::cssc_kind_t       selectedSource,
  output logic [3:0]                 prescaleDivisor
);
  import cssc_pkg::*;

  cssc_regs_t  cur_r;
  cssc_regs_t  cur_nxt;
  logic [6:0]  tickIn;
  logic [6:0]  tickRise;
  logic        wdtTick;
  logic        wakeTick;
  logic        srcTick;
  logic        sysTick;
  logic        srcReserved;
  logic [3:0]  effSel;
  logic [1:0]  effSut;
  cssc_kind_t  kind;
  logic [15:0] wakeTgt;
  logic [15:0] ckTgt;
  logic [13:0] wdtTgt;
  logic        busReq;
  logic        busWr;
  logic [5:0]  regIdx;

  // every pin passes two flops before anything looks at it
  assign tickIn = {wakePin, oscPins};

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : gSync
      cssc_tick_sync uSync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .din     (tickIn[gi]),
        .rise    (tickRise[gi])
      );
    end
  endgenerate

  assign wdtTick  = tickRise[5];
  assign wakeTick = tickRise[6];

  function automatic cssc_kind_t kindOf(input logic [3:0] sel);
    cssc_kind_t k;
    k = KIND_RC;
    if (sel[3]) begin
      k = KIND_XTAL;
    end else begin
      case (sel[2:1])
        2'h0:    k = KIND_EXT;
        2'h1:    k = KIND_RC;
        2'h2:    k = KIND_LFO;
        2'h3:    k = KIND_LFX;
        default: k = KIND_RC;
      endcase
    end
    return k;
  endfunction

  function automatic logic [15:0] wakeCycles(input cssc_kind_t k, input logic [2:0] key);
    logic [15:0] n;
    n = `CSSC_CK_6;
    case (k)
      KIND_LFX:  n = (key[1:0] == 2'h2) ? `CSSC_CK_32K : `CSSC_CK_1K;
      KIND_XTAL: begin
        case (key)
          3'h0, 3'h1:       n = `CSSC_CK_258;
          3'h2, 3'h3, 3'h4: n = `CSSC_CK_1K;
          default:          n = `CSSC_CK_16K;
        endcase
      end
      default:   n = `CSSC_CK_6;
    endcase
    return n;
  endfunction

  function automatic logic [13:0] wdtCycles(input cssc_kind_t k, input logic [2:0] key,
                                            input logic pinDis);
    logic [13:0] n;
    n = WDT_LONG;
    case (k)
      KIND_LFX:  n = (key[1:0] == 2'h0) ? WDT_SHORT : WDT_LONG;
      KIND_XTAL: begin
        case (key)
          3'h2, 3'h5:       n = `CSSC_WDT_NONE;
          3'h0, 3'h3, 3'h6: n = WDT_SHORT;
          default:          n = WDT_LONG;
        endcase
      end
      default: begin
        case (key[1:0])
          2'h0: begin
            n = `CSSC_WDT_NONE;
            if (pinDis == `CSSC_FUSE_PROG && (k == KIND_RC || k == KIND_LFO)) begin
              n = WDT_SHORT;
            end
          end
          2'h1:    n = WDT_SHORT;
          default: n = WDT_LONG;
        endcase
      end
    endcase
    return n;
  endfunction

  // reserved codes map onto the RC source and the longest table entry
  assign srcReserved = ~cur_r.fuse.srcSel[3] & cur_r.fuse.srcSel[0];
  assign effSel      = srcReserved ? `CSSC_SRC_RC : cur_r.fuse.srcSel;
  assign effSut      = (srcReserved | (cur_r.fuse.sutSel == `CSSC_SUT_RSVD && !effSel[3]))
                       ? `CSSC_SUT_LONG : cur_r.fuse.sutSel;
  assign kind        = kindOf(effSel);
  assign wakeTgt     = wakeCycles(kind, {effSel[0], effSut});
  assign wdtTgt      = wdtCycles(kind, {effSel[0], effSut}, cur_r.fuse.rstPinDis);
  // the low-frequency crystal has no fixed cycle part in its reset delay
  assign ckTgt       = (kind == KIND_LFX) ? 16'h0000 : `CSSC_CK_14;

  always_comb begin
    srcTick = 1'b0;
    case (kind)
      KIND_EXT:  srcTick = tickRise[0];
      KIND_RC:   srcTick = tickRise[1];
      KIND_LFO:  srcTick = tickRise[2];
      KIND_LFX:  srcTick = tickRise[3];
      KIND_XTAL: srcTick = tickRise[4];
      default:   srcTick = 1'b0;
    endcase
  end

  assign sysTick = srcTick & (cur_r.divCnt >= cur_r.divisor - `CSSC_DIV_ONE);
  assign busReq  = wb_cyc_i & wb_stb_i & ~cur_r.ack;
  assign busWr   = busReq & wb_we_i;
  assign regIdx  = wb_adr_i[7:2];

  always_comb begin
    cur_nxt          = cur_r;
    cur_nxt.fuseMeta = fusePins;
    cur_nxt.fuseSync = cur_r.fuseMeta;
    cur_nxt.domEn    = 4'h0;
    cur_nxt.ack      = busReq;
    cur_nxt.rdata    = 32'h0000_0000;
    if (srcTick) begin
      cur_nxt.divCnt = sysTick ? 4'h0 : cur_r.divCnt + 4'h1;
    end
    case (cur_r.state)
      ST_LOAD: begin
        cur_nxt.loadCnt = cur_r.loadCnt + 2'h1;
        if (cur_r.loadCnt == `CSSC_LOAD_WAIT) begin
          cur_nxt.fuse    = cur_r.fuseSync;
          cur_nxt.trim    = cur_r.fuseSync.trim;
          cur_nxt.divisor = (cur_r.fuseSync.divEight == `CSSC_FUSE_PROG)
                            ? `CSSC_DIV_EIGHT : `CSSC_DIV_ONE;
          cur_nxt.divCnt  = 4'h0;
          cur_nxt.wdtCnt  = 14'h0000;
          cur_nxt.state   = ST_RESET_WDT;
        end
      end
      ST_RESET_WDT: begin
        // counted on the watchdog oscillator whatever the system source
        if (cur_r.wdtCnt >= wdtTgt) begin
          cur_nxt.ckCnt = 16'h0000;
          cur_nxt.state = ST_RESET_CK;
        end else if (wdtTick) begin
          cur_nxt.wdtCnt = cur_r.wdtCnt + 14'h0001;
        end
      end
      ST_RESET_CK: begin
        if (cur_r.ckCnt >= ckTgt) begin
          cur_nxt.execEn = 1'b1;
          cur_nxt.state  = ST_RUN;
        end else if (srcTick) begin
          cur_nxt.ckCnt = cur_r.ckCnt + 16'h0001;
        end
      end
      ST_RUN: begin
        cur_nxt.domEn = {4{sysTick}};
        if (sleepReq) begin
          cur_nxt.mode   = sleepMode;
          cur_nxt.execEn = 1'b0;
          cur_nxt.state  = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        case (cur_r.mode)
          SLP_IDLE:  cur_nxt.domEn = {sysTick, 1'b0, sysTick, 1'b0};
          SLP_NOISE: cur_nxt.domEn = {sysTick, 3'h0};
          default:   cur_nxt.domEn = 4'h0;
        endcase
        if (wakeTick) begin
          if (cur_r.mode == SLP_IDLE || cur_r.mode == SLP_NOISE) begin
            cur_nxt.execEn = 1'b1;
            cur_nxt.state  = ST_RUN;
          end else begin
            cur_nxt.ckCnt = 16'h0000;
            cur_nxt.state = ST_WAKE;
          end
        end
      end
      ST_WAKE: begin
        // oscillator was stopped; let it settle before code runs again
        if (cur_r.ckCnt >= wakeTgt) begin
          cur_nxt.execEn = 1'b1;
          cur_nxt.state  = ST_RUN;
        end else if (srcTick) begin
          cur_nxt.ckCnt = cur_r.ckCnt + 16'h0001;
        end
      end
      default: begin
        cur_nxt.state = ST_LOAD;
      end
    endcase
    // sticky wake flag, write one to clear; a new wake wins
    if (busWr && regIdx == `CSSC_REG_STATUS && wb_sel_i[2] && wb_dat_i[`CSSC_ST_WAKE_BIT]) begin
      cur_nxt.wakeSeen = 1'b0;
    end
    if (wakeTick) begin
      cur_nxt.wakeSeen = 1'b1;
    end
    if (busWr && regIdx == `CSSC_REG_TRIM && wb_sel_i[0]) begin
      cur_nxt.trim = wb_dat_i[7:0];
    end
    if (busReq && !wb_we_i) begin
      case (regIdx)
        `CSSC_REG_TRIM:   cur_nxt.rdata = {24'h00_0000, cur_r.trim};
        `CSSC_REG_STATUS: cur_nxt.rdata = {13'h0000, srcReserved, cur_r.execEn,
                                           cur_r.wakeSeen, 4'h0, cur_r.divisor,
                                           1'b0, kind, 1'b0, cur_r.state};
        `CSSC_REG_FUSE:   cur_nxt.rdata = {16'h0000, cur_r.fuse};
        default:          cur_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_r                <= '0;
      cur_r.fuse.srcSel    <= `CSSC_SHIP_SRC;
      cur_r.fuse.sutSel    <= `CSSC_SHIP_SUT;
      cur_r.fuse.divEight  <= `CSSC_SHIP_DIV8;
      cur_r.fuse.rstPinDis <= `CSSC_SHIP_RSTDIS;
      cur_r.fuse.trim      <= `CSSC_SHIP_TRIM;
      cur_r.trim           <= `CSSC_SHIP_TRIM;
      cur_r.divisor        <= `CSSC_DIV_EIGHT;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign wb_ack_o             = cur_r.ack;
  assign wb_dat_o             = cur_r.rdata;
  assign coreDomainClock      = cur_r.domEn[0];
  assign ioDomainClock        = cur_r.domEn[1];
  assign flashDomainClock     = cur_r.domEn[2];
  assign converterDomainClock = cur_r.domEn[3];
  assign execEnable           = cur_r.execEn;
  assign oscillatorTrimValue  = cur_r.trim;
  assign selectedSource       = kind;
  assign prescaleDivisor      = cur_r.divisor;
endmodule
`default_nettype wire

// >>> bench/cssc_osc_model.sv
// Purpose: free-running tick levels for every oscillator pin
// Assumes: ref_clk at 10 MHz, pins sampled by a two-flop synchroniser
// Notes:   watchdog slower than sources so the two counts are told apart
`timescale 1ns/1ns
`default_nettype none
module cssc_osc_model (
  input  wire logic           ref_clk,
  output cssc_pkg::cssc_osc_t oscPins
);
  import cssc_pkg::*;
  logic [1:0] srcCnt_r = 2'h0;
  logic [3:0] wdtCnt_r = 4'h0;
  // steady periods, no cycle-to-cycle frequency step
  always @(posedge ref_clk) begin
    srcCnt_r <= srcCnt_r + 2'h1;
    wdtCnt_r <= (wdtCnt_r == 4'h9) ? 4'h0 : wdtCnt_r + 4'h1;
  end
  assign oscPins = {wdtCnt_r > 4'h4, {5{srcCnt_r[1]}}};
endmodule
`default_nettype wire

// >>> bench/cssc_clock_control_checker.sv
// Purpose: concurrent checks on the clock control unit ports
// Assumes: source ticks come at least four ref cycles apart
// Notes:   fuse pins held static outside reset
`timescale 1ns/1ns
`default_nettype none
module cssc_clock_control_checker #(
  parameter logic [13:0] WDT_SHORT = 14'h0200,
  parameter logic [13:0] WDT_LONG  = 14'h2000
) (
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  input wire cssc_pkg::cssc_fuse_t fusePins,
  input wire logic                 sleepReq,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [7:0]           wb_adr_i,
  input wire logic [3:0]           wb_sel_i,
  input wire logic [31:0]          wb_dat_i,
  input wire logic                 wb_ack_o,
  input wire logic                 coreDomainClock,
  input wire logic                 ioDomainClock,
  input wire logic                 flashDomainClock,
  input wire logic                 converterDomainClock,
  input wire logic                 execEnable,
  input wire logic [7:0]           oscillatorTrimValue,
  input wire cssc_pkg::cssc_kind_t selectedSource,
  input wire logic [3:0]           prescaleDivisor
);
  import cssc_pkg::*;
  cssc_kind_t kindExp;
  logic [5:0] upCnt_r;
  logic       take;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_comb begin
    kindExp = KIND_RC;
    if (fusePins.srcSel[3]) kindExp = KIND_XTAL;
    else if (fusePins.srcSel == 4'h0) kindExp = KIND_EXT;
    else if (fusePins.srcSel == 4'h4) kindExp = KIND_LFO;
    else if (fusePins.srcSel == 4'h6) kindExp = KIND_LFX;
  end
  // saturating age since reset release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) upCnt_r <= 6'h00;
    else if (upCnt_r != 6'h3F) upCnt_r <= upCnt_r + 6'h01;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_ack; take |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_trim;
    take && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0] && execEnable
      |=> oscillatorTrimValue == $past(wb_dat_i[7:0]);
  endproperty
  a_trim: assert property (p_trim) else $error("trim not written");
  property p_kind; execEnable |-> selectedSource == kindExp; endproperty
  a_kind: assert property (p_kind) else $error("wrong source");
  property p_div; execEnable |-> prescaleDivisor == (fusePins.divEight ? 4'h1 : 4'h8); endproperty
  a_div: assert property (p_div) else $error("wrong divisor");
  property p_flash; flashDomainClock == coreDomainClock; endproperty
  a_flash: assert property (p_flash) else $error("flash apart from core");
  property p_core; coreDomainClock |-> ioDomainClock && converterDomainClock; endproperty
  a_core: assert property (p_core) else $error("domain missing");
  property p_conv; ioDomainClock |-> converterDomainClock; endproperty
  a_conv: assert property (p_conv) else $error("converter halted");
  property p_late; $rose(execEnable) |-> upCnt_r >= 6'h32; endproperty
  a_late: assert property (p_late) else $error("start too early");
  property p_sleep; sleepReq && execEnable |=> !execEnable; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep ignored");
endmodule
bind cssc_clock_control cssc_clock_control_checker #(
  .WDT_SHORT(WDT_SHORT), .WDT_LONG(WDT_LONG)) cssc_clock_control_checker_i (
  .ref_clk, .rst_n, .fusePins, .sleepReq, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_ack_o, .coreDomainClock, .ioDomainClock, .flashDomainClock,
  .converterDomainClock, .execEnable, .oscillatorTrimValue, .selectedSource,
  .prescaleDivisor);
`default_nettype wire

// >>> bench/tb_top.sv
// Purpose: self-checking bench for the clock control unit
// Assumes: watchdog counts shortened to 4 and 8 ticks
// Notes:   read data matched by a monitor against a queue
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import cssc_pkg::*;
  logic          ref_clk, rst_n, wakePin, sleepReq, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic          coreDomainClock, ioDomainClock, flashDomainClock, converterDomainClock;
  logic          execEnable;
  logic [7:0]    wb_adr_i, oscillatorTrimValue, t;
  logic [3:0]    wb_sel_i, prescaleDivisor;
  logic [31:0]   wb_dat_i, wb_dat_o;
  cssc_fuse_t    fusePins;
  cssc_osc_t     oscPins;
  cssc_slpmode_t sleepMode;
  cssc_kind_t    selectedSource;
  logic [31:0]   expQ[$];
  int            nFail, cmpCount, pc[3];
  // source, start-up code, reset-pin fuse, watchdog ticks, kind
  logic [13:0]   cfg[10] = '{
    {4'h0, 2'h0, 1'b1, 4'h0, 3'h0},
    {4'h0, 2'h1, 1'b1, 4'h4, 3'h0},
    {4'h0, 2'h2, 1'b1, 4'h8, 3'h0},
    {4'h0, 2'h3, 1'b1, 4'h8, 3'h0},
    {4'h2, 2'h0, 1'b1, 4'h0, 3'h1},
    {4'h2, 2'h0, 1'b0, 4'h4, 3'h1},
    {4'h4, 2'h0, 1'b0, 4'h4, 3'h2},
    {4'h4, 2'h1, 1'b1, 4'h4, 3'h2},
    {4'h3, 2'h0, 1'b1, 4'h8, 3'h1},
    {4'h9, 2'h1, 1'b1, 4'h0, 3'h4}
  };
  cssc_osc_model cssc_osc_model_i (.ref_clk, .oscPins);
  cssc_clock_control #(.WDT_SHORT(14'h0004), .WDT_LONG(14'h0008)) cssc_clock_control_i (
    .ref_clk, .rst_n, .fusePins, .oscPins, .wakePin, .sleepReq, .sleepMode, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o,
    .coreDomainClock, .ioDomainClock, .flashDomainClock, .converterDomainClock,
    .execEnable, .oscillatorTrimValue, .selectedSource, .prescaleDivisor);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nFail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    int n;
    @(posedge ref_clk);
    if (!w) expQ.push_back(d);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= w ? d : 32'h0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) chk("ack", 0, 1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  always @(posedge ref_clk) begin
    if (wb_ack_o === 1'b1 && !wb_we_i && expQ.size() > 0)
      chk("rdata", wb_dat_o, expQ.pop_front());
    if (converterDomainClock === 1'b1) pc[0]++;
    if (ioDomainClock === 1'b1) pc[1]++;
    if (coreDomainClock === 1'b1) pc[2]++;
  end
  task automatic boot(input logic [13:0] c, input logic d8);
    int n;
    @(posedge ref_clk);
    rst_n <= 1'b0;
    fusePins <= {c[13:8], d8, c[7], 8'($urandom)};
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    n = 0;
    while (execEnable !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    chk("startup", n >= c[6:3] * 10 + 50 && n <= c[6:3] * 10 + 90, 1);
    chk("kind", selectedSource, c[2:0]);
    chk("divisor", prescaleDivisor, d8 ? 4'h1 : 4'h8);
    chk("trim", oscillatorTrimValue, fusePins.trim);
    wb(1'b0, 8'h00, fusePins.trim);
    // status after start-up: run state, exec on, no wake seen, fallback flag
    wb(1'b0, 8'h04, {13'h0, ~c[13] & c[10], 2'b10, 4'h0, d8 ? 4'h1 : 4'h8, 1'b0, c[2:0], 4'h3});
  endtask
  task automatic dom(input logic [2:0] msk);
    repeat (2) @(posedge ref_clk);
    pc = '{0, 0, 0};
    repeat (80) @(posedge ref_clk);
    foreach (pc[i]) chk("domain", pc[i] > 0, msk[i]);
  endtask
  task automatic sleepWake(input logic [1:0] m);
    int n;
    @(posedge ref_clk);
    sleepMode <= cssc_slpmode_t'(m);
    sleepReq <= 1'b1;
    @(posedge ref_clk);
    sleepReq <= 1'b0;
    dom(m == 2'h0 ? 3'b011 : m == 2'h1 ? 3'b001 : 3'b000);
    chk("exec", execEnable, 0);
    wakePin <= 1'b1;
    n = 0;
    while (execEnable !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    chk("wake", m[1] ? (n >= 22 && n <= 40) : n <= 8, 1);
    wakePin <= 1'b0;
  endtask
  initial begin
    void'($urandom(32'h672d));
    {rst_n, wakePin, sleepReq, wb_cyc_i, wb_stb_i, wb_we_i} = 6'h00;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    sleepMode = SLP_IDLE;
    fusePins = 16'hFFFF;
    foreach (cfg[i]) boot(cfg[i], 1'($urandom));
    boot({4'h2, 2'h2, 1'b1, 4'h8, 3'h1}, 1'b0);
    wb(1'b0, 8'h08, {16'h0, fusePins});
    wb(1'b1, 8'h08, 32'hFFFF_FFFF);
    wb(1'b0, 8'h08, {16'h0, fusePins});
    wb(1'b0, 8'h40, 32'h0);
    t = 8'($urandom);
    wb(1'b1, 8'h00, {24'h0, t});
    wb(1'b0, 8'h00, {24'h0, t});
    chk("trim", oscillatorTrimValue, t);
    // lane 0 not selected: the trim must keep its value
    wb(1'b1, 8'h00, {24'h0, ~t}, 4'hE);
    wb(1'b0, 8'h00, {24'h0, t});
    dom(3'b111);
    for (int m = 0; m < 4; m++) sleepWake(2'(m));
    wb(1'b0, 8'h04, 32'h0003_0813);
    wb(1'b1, 8'h04, 32'h0001_0000, 4'hB);
    wb(1'b0, 8'h04, 32'h0003_0813);
    wb(1'b1, 8'h04, 32'h0001_0000);
    wb(1'b0, 8'h04, 32'h0002_0813);
    summarize();
  end
  initial begin
    #(100 * 30000);
    nFail++;
    summarize();
  end
endmodule
`default_nettype wire
